// ===== hw/phy_regs_params.svh
`ifndef PHY_REGS_PARAMS_SVH
`define PHY_REGS_PARAMS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define REG_LINK_STATUS 5'h13
`define REG_RX_ERR_CNT 5'h15
`define REG_IND_SEL 5'h16
`define REG_IND_BEH 5'h17
`define REG_MDIO_DRV 5'h19
`define REG_IND_MODE 5'h1A
`define REG_EVT 5'h1B
`define REG_CTRL 5'h1F

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define SEL_TWO_MSB 7
`define SEL_TWO_LSB 4
`define SEL_ONE_MSB 3
`define SEL_ONE_LSB 0
`define SEL_TWO_RST 4'h2
`define SEL_ONE_RST 4'h1
`define BEH_RATE_MSB 11
`define BEH_RATE_LSB 10
`define BEH_RATE_RST 2'h0
`define BEH_STRETCH_MSB 6
`define BEH_STRETCH_LSB 5
`define BEH_COMB_MSB 1
`define BEH_COMB_LSB 0
`define DRV_PP_BIT 1
`define DRV_PP_RST 1'b0
`define MODE_LEGACY_BIT 14
`define MODE_LEGACY_RST 1'b1
`define EVT_EN_MSB 15
`define EVT_EN_LSB 8
`define EVT_RX_ERR_BIT 6
`define CTRL_IRQ_INV_BIT 14
`define RX_ERR_MAX 16'hFFFF

// ----------------------------------------
// indicator function codes
// ----------------------------------------
`define FN_LINK_1000 4'h0
`define FN_LINK_ANY 4'h1
`define FN_DUPLEX 4'h2
`define FN_LINK_100 4'h3

// ----------------------------------------
// management frame
// ----------------------------------------
`define MDIO_PRE_LEN 6'd32
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1
`define PHY_ADDR_DEFAULT 5'h01

// ----------------------------------------
// timing: one tick is the 50 ms stretch / 2
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define IND_TICK_MS 25
`define IND_TICK_CYCLES (`IND_TICK_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// ===== hw/phy_regs_pkg.sv
package phy_regs_pkg;

	typedef enum logic [5:0] {
		S_PRE = 6'h01,
		S_ST = 6'h02,
		S_HDR = 6'h04,
		S_TA_RD = 6'h08,
		S_RD = 6'h10,
		S_WR = 6'h20
	} mdio_state_e;

	typedef logic [15:0] reg_word_t;

endpackage

// ===== hw/ind_cfg_if.sv
`timescale 1ns/10ps
`default_nettype none

interface ind_cfg_if;
	logic legacy;
	logic [3:0] sel_one;
	logic [3:0] sel_two;
	logic [1:0] rate;
	logic [1:0] stretch;
	logic [1:0] comb_dis;

	modport ctrl (output legacy, sel_one, sel_two, rate, stretch, comb_dis);
	modport drive (input legacy, sel_one, sel_two, rate, stretch, comb_dis);
endinterface

`default_nettype wire

// ===== hw/status_events.sv
`timescale 1ns/10ps
`default_nettype none
`include "phy_regs_params.svh"

module status_events import phy_regs_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic rx_error,
	input wire logic [7:0] event_in,
	input wire logic [7:0] enable,
	input wire logic irq_invert,
	input wire logic cnt_clear,
	input wire logic evt_clear,
	output reg_word_t cnt_q,
	output logic [7:0] flags_q,
	output logic irq_q
);
	logic [7:0] evt;

	always_comb begin
		evt = event_in;
		evt[`EVT_RX_ERR_BIT] = event_in[`EVT_RX_ERR_BIT] | rx_error;
	end

	// a count arriving with the read-clear survives as one
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 16'h0000;
		end else if (cnt_clear) begin
			cnt_q <= rx_error ? 16'h0001 : 16'h0000;
		end else if (rx_error && cnt_q != `RX_ERR_MAX) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_flag
			// set wins over the read-clear
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					flags_q[i] <= 1'b0;
				end else begin
					flags_q[i] <= (flags_q[i] & ~evt_clear) | evt[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (|(flags_q & enable)) ^ irq_invert;
		end
	end
endmodule

`default_nettype wire

// ===== hw/indicator_drive.sv
`timescale 1ns/10ps
`default_nettype none
`include "phy_regs_params.svh"

module indicator_drive import phy_regs_pkg::*; #(
	parameter int unsigned TICK_CYCLES = `IND_TICK_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	ind_cfg_if.drive cfg,
	input wire logic link_1000,
	input wire logic link_100,
	input wire logic activity,
	input wire logic duplex_full,
	input wire logic collision,
	output logic [1:0] ind_q
);
	logic [31:0] tick_cnt_q;
	logic tick;
	logic [1:0] rate;
	logic [1:0] stretch;
	logic [1:0] comb_dis;
	logic [3:0] sel [2];
	logic [4:0] len;
	logic [4:0] phase_cnt_q;
	logic phase_q;

	// legacy mode falls back to the reset configuration
	always_comb begin
		rate = cfg.legacy ? `BEH_RATE_RST : cfg.rate;
		stretch = cfg.legacy ? 2'b00 : cfg.stretch;
		comb_dis = cfg.legacy ? 2'b00 : cfg.comb_dis;
		sel[0] = cfg.legacy ? `SEL_ONE_RST : cfg.sel_one;
		sel[1] = cfg.legacy ? `SEL_TWO_RST : cfg.sel_two;
		case (rate)
			2'h0: len = 5'd16;
			2'h1: len = 5'd8;
			2'h2: len = 5'd4;
			default: len = 5'd2;
		endcase
	end

	assign tick = (tick_cnt_q == TICK_CYCLES - 1);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt_q <= 32'h0;
		end else begin
			tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
		end
	end

	// blink half period is half the stretch length
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_cnt_q <= 5'h0;
			phase_q <= 1'b0;
		end else if (tick) begin
			if (phase_cnt_q >= (len >> 1) - 5'd1) begin
				phase_cnt_q <= 5'h0;
				phase_q <= ~phase_q;
			end else begin
				phase_cnt_q <= phase_cnt_q + 5'd1;
			end
		end
	end

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_ind
			logic prim;
			logic partner;
			logic busy;
			logic [4:0] busy_q;

			always_comb begin
				case (sel[i])
					`FN_LINK_1000: prim = link_1000;
					`FN_LINK_ANY: prim = link_1000 | link_100;
					`FN_DUPLEX: prim = duplex_full;
					`FN_LINK_100: prim = link_100;
					default: prim = 1'b0;
				endcase
				partner = (sel[i] == `FN_DUPLEX) ? collision : activity;
				busy = (busy_q != 5'h0);
			end

			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					busy_q <= 5'h0;
				end else if (partner) begin
					busy_q <= len;
				end else if (tick && busy) begin
					busy_q <= busy_q - 5'd1;
				end
			end

			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					ind_q[i] <= 1'b0;
				end else if (comb_dis[i]) begin
					ind_q[i] <= prim;
				end else if (stretch[i]) begin
					ind_q[i] <= prim & ~busy;
				end else begin
					ind_q[i] <= prim & ~(busy & phase_q);
				end
			end
		end
	endgenerate
endmodule

`default_nettype wire

// ===== hw/phy_status_led_irq_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "phy_regs_params.svh"

module phy_status_led_irq_regs import phy_regs_pkg::*; #(
	parameter int unsigned TICK_CYCLES = `IND_TICK_CYCLES,
	parameter logic [4:0] PHY_ADDR = `PHY_ADDR_DEFAULT
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	input wire logic link_good_1000,
	input wire logic link_good_100,
	input wire logic rx_error,
	input wire logic [7:0] event_in,
	input wire logic link_activity,
	input wire logic duplex_full,
	input wire logic collision,
	output logic irq_out,
	output logic indicator_out_one,
	output logic indicator_out_two
);
	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [1:0] link_q;
	logic [3:0] sel_one_q;
	logic [3:0] sel_two_q;
	logic [1:0] rate_q;
	logic [1:0] stretch_q;
	logic [1:0] comb_q;
	logic pp_q;
	logic legacy_q;
	logic [7:0] en_q;
	logic inv_q;

	// ----------------------------------------
	// management frame engine
	// ----------------------------------------
	mdio_state_e state_q;
	logic mdc_q;
	logic rise;
	logic [5:0] pre_cnt_q;
	logic [4:0] bit_cnt_q;
	reg_word_t sh_q;
	logic [4:0] regad_q;
	logic drv_en_q;
	logic drv_bit_q;
	logic mdio_out_q;
	logic mdio_oe_q;
	logic [11:0] hdr;
	reg_word_t wdata;
	reg_word_t rdata;
	logic wr_fire;
	logic rd_fire;

	reg_word_t cnt;
	logic [7:0] flags;
	logic irq_q;
	logic [1:0] ind_q;

	ind_cfg_if cfg_bus ();

	assign rise = mdc & ~mdc_q;
	assign hdr = {sh_q[10:0], mdio_in};
	assign wdata = {sh_q[14:0], mdio_in};
	// two turnaround bits then sixteen data bits: D0 lands on count 17
	assign wr_fire = rise && state_q == S_WR && bit_cnt_q == 5'd17;
	// read data is captured on the first turnaround bit
	assign rd_fire = rise && state_q == S_TA_RD;

	always_comb begin
		rdata = 16'h0000;
		case (regad_q)
			`REG_LINK_STATUS: rdata[1:0] = link_q;
			`REG_RX_ERR_CNT: rdata = cnt;
			`REG_IND_SEL: begin
				rdata[`SEL_TWO_MSB:`SEL_TWO_LSB] = sel_two_q;
				rdata[`SEL_ONE_MSB:`SEL_ONE_LSB] = sel_one_q;
			end
			`REG_IND_BEH: begin
				rdata[`BEH_RATE_MSB:`BEH_RATE_LSB] = rate_q;
				rdata[`BEH_STRETCH_MSB:`BEH_STRETCH_LSB] = stretch_q;
				rdata[`BEH_COMB_MSB:`BEH_COMB_LSB] = comb_q;
			end
			`REG_MDIO_DRV: rdata[`DRV_PP_BIT] = pp_q;
			`REG_IND_MODE: rdata[`MODE_LEGACY_BIT] = legacy_q;
			`REG_EVT: rdata = {en_q, flags};
			`REG_CTRL: rdata[`CTRL_IRQ_INV_BIT] = inv_q;
			default: rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mdc_q <= 1'b0;
		end else begin
			mdc_q <= mdc;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= S_PRE;
			pre_cnt_q <= 6'h0;
			bit_cnt_q <= 5'h0;
			sh_q <= 16'h0000;
			regad_q <= 5'h0;
			drv_en_q <= 1'b0;
			drv_bit_q <= 1'b0;
		end else if (rise) begin
			case (state_q)
				S_PRE: begin
					if (mdio_in) begin
						if (pre_cnt_q != `MDIO_PRE_LEN) begin
							pre_cnt_q <= pre_cnt_q + 6'd1;
						end
					end else begin
						pre_cnt_q <= 6'h0;
						if (pre_cnt_q == `MDIO_PRE_LEN) begin
							state_q <= S_ST;
						end
					end
				end
				S_ST: begin
					bit_cnt_q <= 5'h0;
					state_q <= mdio_in ? S_HDR : S_PRE;
				end
				S_HDR: begin
					sh_q <= wdata;
					bit_cnt_q <= bit_cnt_q + 5'd1;
					if (bit_cnt_q == 5'd11) begin
						bit_cnt_q <= 5'h0;
						regad_q <= hdr[4:0];
						if (hdr[9:5] != PHY_ADDR) begin
							state_q <= S_PRE;
						end else if (hdr[11:10] == `MDIO_OP_READ) begin
							state_q <= S_TA_RD;
						end else if (hdr[11:10] == `MDIO_OP_WRITE) begin
							state_q <= S_WR;
						end else begin
							state_q <= S_PRE;
						end
					end
				end
				S_TA_RD: begin
					sh_q <= rdata;
					drv_en_q <= 1'b1;
					drv_bit_q <= 1'b0;
					bit_cnt_q <= 5'h0;
					state_q <= S_RD;
				end
				S_RD: begin
					bit_cnt_q <= bit_cnt_q + 5'd1;
					if (bit_cnt_q == 5'd16) begin
						drv_en_q <= 1'b0;
						state_q <= S_PRE;
					end else begin
						drv_bit_q <= sh_q[15];
						sh_q <= {sh_q[14:0], 1'b0};
					end
				end
				S_WR: begin
					// the turnaround bits shift out of the word before D0 arrives
					sh_q <= wdata;
					bit_cnt_q <= bit_cnt_q + 5'd1;
					if (wr_fire) begin
						bit_cnt_q <= 5'h0;
						state_q <= S_PRE;
					end
				end
				default: state_q <= S_PRE;
			endcase
		end
	end

	// open-drain only ever pulls low; push-pull drives both levels
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mdio_out_q <= 1'b0;
			mdio_oe_q <= 1'b0;
		end else begin
			mdio_out_q <= pp_q & drv_bit_q;
			mdio_oe_q <= drv_en_q & (pp_q | ~drv_bit_q);
		end
	end

	// ----------------------------------------
	// register writes and link status capture
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			link_q <= 2'b00;
		end else begin
			link_q <= {link_good_1000, link_good_100};
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sel_one_q <= `SEL_ONE_RST;
			sel_two_q <= `SEL_TWO_RST;
		end else if (wr_fire && regad_q == `REG_IND_SEL) begin
			sel_one_q <= wdata[`SEL_ONE_MSB:`SEL_ONE_LSB];
			sel_two_q <= wdata[`SEL_TWO_MSB:`SEL_TWO_LSB];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rate_q <= `BEH_RATE_RST;
			stretch_q <= 2'b00;
			comb_q <= 2'b00;
		end else if (wr_fire && regad_q == `REG_IND_BEH) begin
			rate_q <= wdata[`BEH_RATE_MSB:`BEH_RATE_LSB];
			stretch_q <= wdata[`BEH_STRETCH_MSB:`BEH_STRETCH_LSB];
			comb_q <= wdata[`BEH_COMB_MSB:`BEH_COMB_LSB];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pp_q <= `DRV_PP_RST;
		end else if (wr_fire && regad_q == `REG_MDIO_DRV) begin
			pp_q <= wdata[`DRV_PP_BIT];
		end
	end

	// legacy defaults on; the station is expected to keep it set
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			legacy_q <= `MODE_LEGACY_RST;
		end else if (wr_fire && regad_q == `REG_IND_MODE) begin
			legacy_q <= wdata[`MODE_LEGACY_BIT];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			en_q <= 8'h00;
		end else if (wr_fire && regad_q == `REG_EVT) begin
			en_q <= wdata[`EVT_EN_MSB:`EVT_EN_LSB];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			inv_q <= 1'b0;
		end else if (wr_fire && regad_q == `REG_CTRL) begin
			inv_q <= wdata[`CTRL_IRQ_INV_BIT];
		end
	end

	// ----------------------------------------
	// events, counter and indicators
	// ----------------------------------------
	status_events u_events (
		.clk(clk),
		.reset_n(reset_n),
		.rx_error(rx_error),
		.event_in(event_in),
		.enable(en_q),
		.irq_invert(inv_q),
		.cnt_clear(rd_fire && regad_q == `REG_RX_ERR_CNT),
		.evt_clear(rd_fire && regad_q == `REG_EVT),
		.cnt_q(cnt),
		.flags_q(flags),
		.irq_q(irq_q)
	);

	assign cfg_bus.legacy = legacy_q;
	assign cfg_bus.sel_one = sel_one_q;
	assign cfg_bus.sel_two = sel_two_q;
	assign cfg_bus.rate = rate_q;
	assign cfg_bus.stretch = stretch_q;
	assign cfg_bus.comb_dis = comb_q;

	indicator_drive #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_ind (
		.clk(clk),
		.reset_n(reset_n),
		.cfg(cfg_bus.drive),
		.link_1000(link_good_1000),
		.link_100(link_good_100),
		.activity(link_activity),
		.duplex_full(duplex_full),
		.collision(collision),
		.ind_q(ind_q)
	);

	assign mdio_out = mdio_out_q;
	assign mdio_oe = mdio_oe_q;
	assign irq_out = irq_q;
	assign indicator_out_one = ind_q[0];
	assign indicator_out_two = ind_q[1];
endmodule

`default_nettype wire

// ===== test/phy_regs_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module phy_regs_asserts (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic mdc,
	input wire logic mdio_in,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	input wire logic rx_error,
	input wire logic [7:0] event_in,
	input wire logic irq_out,
	input wire logic indicator_out_one,
	input wire logic indicator_out_two
);
	logic mdc_q;
	logic [2:0] age_q;
	logic [4:0] oe_rises_q;

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mdc_q <= 1'b0;
		end else begin
			mdc_q <= mdc;
		end
	end

	// cycles since the last management clock rise, saturating
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			age_q <= 3'h7;
		end else if (mdc && !mdc_q) begin
			age_q <= 3'h0;
		end else if (age_q != 3'h7) begin
			age_q <= age_q + 3'h1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			oe_rises_q <= 5'h00;
		end else if (!mdio_oe) begin
			oe_rises_q <= 5'h00;
		end else if (mdc && !mdc_q) begin
			oe_rises_q <= oe_rises_q + 5'h01;
		end
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	sequence drive_start;
		$rose(mdio_oe) ##0 !mdio_out;
	endsequence

	sequence drive_held;
		mdio_oe [*4];
	endsequence

	rst_quiet_a: assert property ($rose(reset_n) |-> !mdio_oe && !irq_out && !indicator_out_one && !indicator_out_two)
		else $error("outputs not idle after reset");
	ta_zero_a: assert property ($rose(mdio_oe) |-> drive_start)
		else $error("turnaround bit not driven low");
	oe_hold_a: assert property (drive_start |-> drive_held)
		else $error("data output dropped early");
	out_change_a: assert property ($changed(mdio_out) || $changed(mdio_oe) |-> age_q inside {[1:3]})
		else $error("data output moved away from a clock rise");
	out_with_oe_a: assert property ($rose(mdio_out) |-> mdio_oe)
		else $error("data high without enable");
	oe_len_a: assert property (oe_rises_q <= 5'd17)
		else $error("read drive too long");
	ta_release_a: assert property ($rose(mdio_oe) |-> $past(mdio_in) && $past(mdio_in, 2))
		else $error("drive began before turnaround");
	irq_cause_a: assert property ($changed(irq_out) |-> $past(|event_in || rx_error, 2) || age_q inside {[1:4]})
		else $error("interrupt moved without cause");
endmodule

bind phy_status_led_irq_regs phy_regs_asserts i_phy_regs_asserts (
	.clk(clk),
	.reset_n(reset_n),
	.mdc(mdc),
	.mdio_in(mdio_in),
	.mdio_out(mdio_out),
	.mdio_oe(mdio_oe),
	.rx_error(rx_error),
	.event_in(event_in),
	.irq_out(irq_out),
	.indicator_out_one(indicator_out_one),
	.indicator_out_two(indicator_out_two)
);

`default_nettype wire

// ===== test/mdio_station.sv
`timescale 1ns/10ps
`default_nettype none
`include "phy_regs_params.svh"

module mdio_station import phy_regs_pkg::*; (
	input wire logic clk,
	input wire logic line,
	output logic mdc,
	output logic drv_en,
	output logic drv_val
);
	initial begin
		mdc = 1'b0;
		drv_en = 1'b0;
		drv_val = 1'b1;
	end

	// one bit: data set in the low phase, sampled as the clock rises
	task automatic bit_cyc(input logic en, input logic v, output logic s);
		mdc = 1'b0;
		drv_en = en;
		drv_val = v;
		repeat (3) @(negedge clk);
		mdc = 1'b1;
		s = line;
		repeat (3) @(negedge clk);
	endtask

	task automatic xfer(input logic rd, input logic [4:0] ra, input reg_word_t wd, output reg_word_t rdat);
		logic [45:0] hdr;
		logic s;
		hdr = {32'hFFFFFFFF, 2'b01, rd ? `MDIO_OP_READ : `MDIO_OP_WRITE, `PHY_ADDR_DEFAULT, ra};
		rdat = 16'h0000;
		for (int i = 45; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
		bit_cyc(!rd, 1'b1, s);
		bit_cyc(!rd, 1'b0, s);
		for (int i = 15; i >= 0; i--) begin
			bit_cyc(!rd, wd[i], s);
			rdat[i] = s;
		end
		drv_en = 1'b0;
	endtask
endmodule

`default_nettype wire

// ===== test/phy_status_led_irq_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none

module phy_status_led_irq_regs_tb import phy_regs_pkg::*;;
	logic clk, reset_n, l1000, l100, rx_error, duplex_full, saw_pp, act;
	logic mdc, mdio_out, mdio_oe, drv_en, drv_val, line, irq_out, ind_one, ind_two;
	logic [7:0] event_in, en;
	int bad_count, n_tests, seed, cycles, cnt_m;
	reg_word_t rd, wd;
	logic [4:0] ra_v [8] = '{5'h13, 5'h15, 5'h16, 5'h17, 5'h19, 5'h1A, 5'h1B, 5'h10};
	reg_word_t rst_v [8] = '{16'h0000, 16'h0000, 16'h0021, 16'h0000, 16'h0000, 16'h4000, 16'h0000, 16'h0000};
	reg_word_t msk_v [8] = '{16'h0000, 16'h0000, 16'h00FF, 16'h0C63, 16'h0002, 16'h4000, 16'hFF00, 16'h0000};

	// pull-up holds the line high when nobody drives
	assign line = mdio_oe ? mdio_out : (drv_en ? drv_val : 1'b1);

	phy_status_led_irq_regs #(.TICK_CYCLES(8)) i_phy_status_led_irq_regs (.clk(clk), .reset_n(reset_n),
		.mdc(mdc), .mdio_in(line), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .link_good_1000(l1000),
		.link_good_100(l100), .rx_error(rx_error), .event_in(event_in), .link_activity(act),
		.duplex_full(duplex_full), .collision(1'b0), .irq_out(irq_out), .indicator_out_one(ind_one),
		.indicator_out_two(ind_two));
	mdio_station i_mdio_station (.clk(clk), .line(line), .mdc(mdc), .drv_en(drv_en), .drv_val(drv_val));

	always #5 clk = ~clk;

	always @(posedge clk) begin
		if (mdio_oe && mdio_out) saw_pp = 1'b1;
		cycles++;
		if (cycles == 95000) begin
			bad_count++;
			$display("[FAIL] %0t timeout", $time);
			complete_run;
		end
	end

	task automatic chk16(input reg_word_t got, input reg_word_t exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t pin %b expected %b", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input reg_word_t d);
		i_mdio_station.xfer(1'b0, a, d, rd);
		repeat (3) @(negedge clk);
	endtask

	task automatic rdc(input logic [4:0] a, input reg_word_t exp);
		i_mdio_station.xfer(1'b1, a, 16'h0000, rd);
		chk16(rd, exp);
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		{l1000, l100, rx_error, duplex_full, saw_pp, act} = 6'h00;
		event_in = 8'h00;
		seed = 29502;
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		repeat (2) @(negedge clk);
		for (int i = 0; i < 8; i++) rdc(ra_v[i], rst_v[i]);
		for (int i = 0; i < 8; i++) begin
			wd = $random(seed);
			if (i == 4) wd[1] = 1'b0;
			wr(ra_v[i], wd);
			rdc(ra_v[i], wd & msk_v[i]);
		end
		wr(5'h1A, 16'h4000);
		wr(5'h1B, 16'h0000);
		{l1000, l100} = 2'($random(seed));
		repeat (2) @(negedge clk);
		rdc(5'h13, {14'h0000, l1000, l100});
		cnt_m = ($random(seed) & 15) + 1;
		for (int i = 0; i < cnt_m; i++) begin
			rx_error = 1'b1;
			@(negedge clk);
			rx_error = 1'b0;
			@(negedge clk);
		end
		rdc(5'h15, 16'(cnt_m));
		rdc(5'h15, 16'h0000);
		rdc(5'h1B, 16'h0040);
		rx_error = 1'b1;
		repeat (65540) @(negedge clk);
		rx_error = 1'b0;
		cnt_m = (65540 > 65535) ? 65535 : 65540;
		rdc(5'h15, 16'(cnt_m));
		rdc(5'h1B, 16'h0040);
		for (int b = 0; b < 8; b++) begin
			en = 8'($random(seed));
			wr(5'h1B, {en, 8'h00});
			event_in = 8'h01 << b;
			@(negedge clk);
			event_in = 8'h00;
			repeat (3) @(negedge clk);
			chk1(irq_out, en[b]);
			rdc(5'h1B, {en, 8'h01 << b});
			chk1(irq_out, 1'b0);
		end
		wr(5'h1F, 16'h4000);
		chk1(irq_out, 1'b1);
		wr(5'h1F, 16'h0000);
		chk1(irq_out, 1'b0);
		chk1(saw_pp, 1'b0);
		wr(5'h19, 16'h0002);
		rdc(5'h1A, 16'h4000);
		chk1(saw_pp, 1'b1);
		wr(5'h19, 16'h0000);
		{l1000, l100, duplex_full} = 3'b011;
		wr(5'h16, 16'h0030);
		repeat (4) @(negedge clk);
		chk1(ind_one, 1'b1);
		chk1(ind_two, 1'b1);
		wr(5'h1A, 16'h0000);
		repeat (4) @(negedge clk);
		chk1(ind_one, 1'b0);
		chk1(ind_two, 1'b1);
		wr(5'h16, 16'h0001);
		wr(5'h17, 16'h0C20);
		act = 1'b1;
		@(negedge clk);
		act = 1'b0;
		repeat (2) @(negedge clk);
		chk1(ind_one, 1'b0);
		repeat (40) @(negedge clk);
		chk1(ind_one, 1'b1);
		wr(5'h1A, 16'h4000);
		repeat (4) @(negedge clk);
		chk1(ind_one, 1'b1);
		complete_run;
	end
endmodule

`default_nettype wire
